// [verilog/lcdms_pkg.sv]
// Constants for the LCD display-memory and panel scan core
// How it works
// - Address set loads addr_counter and picks memory from ram_select.
// - Every host data write or read steps addr_counter up or down by one.
// - char_code_ram holds 80 eight-bit codes, five lines of sixteen.
// - Line n of char_code_ram starts at (n-1)*16, from 00 to 4F.
// - Graphics mode shows user_font_ram as a 96 x 40 bitmap, ignoring codes.
// - font_rom turns codes into 6 x 8 glyphs; bank gives 240 or 192 glyphs.
// - Character mode lets codes pick up to 64 user_font_ram glyphs at once.
// - icon_ram holds 96 x 2 bits, one half per icon common.
// - Icon bits drive segments directly, not via character or font RAM.
// - Refresh reads and host accesses use separate ports, so no flicker.
// - Cursor, blink or reversal sits where addr_counter points.
// - 42 commons and 96 segments; unused commons stay unselected.
// - Row data shifts serially into 96 bits and latches only when complete.
// - seg_reverse and common_reverse flip segment and common output order.
// - Drive off, standby or sleep puts every driver at ground.
// - Standby stops the internal oscillator.
// - Software picks booster factor from single to quadruple.
// - Software picks bias ratio from one-half to one-eighth.
// - Software may switch followers off only while drive is unused.
// - Contrast setting has 32 steps.
// - line_count 001 to 101 gives one to five lines, eight commons each.
// - start_line picks the first common group's line, later groups wrap.
// - First read after an address set is a dummy; later reads valid.
// - ram_select 10 selects user_font_ram; 01 selects no memory.
package lcdms_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_POWER = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_DISP_ON = 0;
  localparam int CTRL_STANDBY = 1;
  localparam int CTRL_SLEEP = 2;
  localparam int CTRL_GRAPHICS = 3;
  localparam int CTRL_LINES_LSB = 4;
  localparam int CTRL_START_LSB = 8;
  localparam int CTRL_SEG_REV = 12;
  localparam int CTRL_COM_REV = 13;
  localparam int CTRL_CURSOR = 14;
  localparam int CTRL_BLINK = 15;
  localparam int CTRL_FONT_BANK = 16;
  localparam int CTRL_INC = 17;
  localparam logic [31:0] CTRL_MASK = 32'h0003_F77F;
  localparam logic [31:0] CTRL_RST = 32'h0002_0010;
  // ---------------------------------------------------------------
  // Power register fields and address register layout
  // ---------------------------------------------------------------
  localparam int PWR_BOOST_LSB = 0;
  localparam int PWR_BIAS_LSB = 4;
  localparam int PWR_FOLLOWER = 8;
  localparam int PWR_CONTRAST_LSB = 16;
  localparam logic [31:0] PWR_MASK = 32'h001F_0173;
  localparam logic [31:0] PWR_RST = 32'h0000_0000;
  localparam int ADDR_SEL_LSB = 12;
  // ---------------------------------------------------------------
  // Memory selection and geometry
  // ---------------------------------------------------------------
  localparam logic [1:0] RS_CHAR = 2'b00;
  localparam logic [1:0] RS_FONT = 2'b10;
  localparam logic [1:0] RS_ICON = 2'b11;
  localparam int CC_DEPTH = 80;
  localparam int UF_DEPTH = 480;
  localparam int SEGS = 96;
  localparam int COMS = 42;
  localparam int LINES = 5;
  localparam int ICON_COM_A = 40;
  localparam int ICON_COM_B = 41;
  localparam logic [2:0] GRP_ICON_A = 3'd5;
  localparam logic [2:0] GRP_ICON_B = 3'd6;
  localparam int BLINK_BIT = 4;
endpackage

// [verilog/lcdms_scan.sv]
// Display memories, address counter, glyph lookup and panel scan
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module lcdms_scan
  import lcdms_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // Clock, reset and clock enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Panel drivers
  output logic [SEGS-1:0] segOut,
  output logic [COMS-1:0] comSel,
  output logic driveOn,
  // Power settings
  output logic oscStop,
  output logic [1:0] boostFactor,
  output logic [2:0] biasRatio,
  output logic followerOn,
  output logic [4:0] contrastLevel
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [10:0] ac;
    logic [1:0] ramSel;
    logic [7:0] dataReg;
    logic [31:0] ctrl;
    logic [31:0] power;
    logic [2:0] grp;
    logic [2:0] row;
    logic [6:0] col;
    logic [3:0] chr;
    logic [2:0] dot;
    logic [SEGS-1:0] shift;
    logic [SEGS-1:0] seg;
    logic [COMS-1:0] com;
    logic drive;
    logic follower;
    logic [4:0] frame;
  } lcdms_state_t;

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstN;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // -----------------------------------------------------------------
  // Memories
  // -----------------------------------------------------------------
  logic [7:0] ccRam [CC_DEPTH];
  logic [7:0] ufRam [UF_DEPTH];
  logic [1:0] iconRam [SEGS];

  // Stand-in glyph artwork; the real table is a mask option
  function automatic logic [7:0] rom_byte(input logic [7:0] code,
                                          input logic [2:0] dot);
    rom_byte = (dot == 3'd5) ? 8'h00 : {1'b0, code[6:0] ^ {4'h0, dot}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old & ~m) | (dat & m);
  endfunction

  lcdms_state_t s;
  lcdms_state_t n;
  logic take;
  logic ccWe;
  logic ufWe;
  logic icWe;
  logic hostOk;
  logic [8:0] hostIdx;
  logic [7:0] hostRd;
  logic [2:0] nLines;
  logic [2:0] startSel;
  logic [2:0] lineGrp;
  logic [3:0] lineSum;
  logic [2:0] dispLine;
  logic [6:0] ccIdx;
  logic [7:0] code;
  logic isUser;
  logic [6:0] ufCol;
  logic [8:0] ufIdx;
  logic [7:0] pattern;
  logic atCursor;
  logic pix;
  logic blank;
  logic [5:0] comIdx;
  logic [SEGS-1:0] rowBits;

  localparam lcdms_state_t ST_RST =
    '{ctrl: CTRL_RST, power: PWR_RST, default: '0};

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    n = s;
    ccWe = 1'b0;
    ufWe = 1'b0;
    icWe = 1'b0;
    hostOk = 1'b0;
    hostIdx = 9'h000;
    hostRd = 8'h00;
    take = wb_cyc_i & wb_stb_i & ~s.ack;
    n.ack = take;

    // Host-side memory port, independent of the refresh port
    unique case (s.ramSel)
      RS_CHAR: begin
        hostOk = s.ac < 11'(CC_DEPTH);
        hostIdx = {2'b00, s.ac[6:0]};
        hostRd = hostOk ? ccRam[s.ac[6:0]] : 8'h00;
      end
      RS_FONT: begin
        hostOk = (s.ac[10:8] < 3'(LINES)) && (s.ac[7:0] < 8'(SEGS));
        hostIdx = 9'(s.ac[10:8]) * 9'(SEGS) + 9'(s.ac[6:0]);
        hostRd = hostOk ? ufRam[hostIdx] : 8'h00;
      end
      RS_ICON: begin
        hostOk = s.ac < 11'(SEGS);
        hostIdx = {2'b00, s.ac[6:0]};
        hostRd = hostOk ? {6'h00, iconRam[s.ac[6:0]]} : 8'h00;
      end
      default: begin
        hostOk = 1'b0;
      end
    endcase

    if (take) begin
      n.rdat = 32'h0000_0000;
      unique case (8'(wb_adr_i))
        OFS_CTRL: begin
          n.rdat = s.ctrl;
          if (wb_we_i) begin
            n.ctrl = merge(s.ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
          end
        end
        OFS_ADDR: begin
          n.rdat = {18'h0, s.ramSel, 1'b0, s.ac};
          if (wb_we_i) begin
            n.ac = wb_dat_i[10:0];
            n.ramSel = wb_dat_i[ADDR_SEL_LSB+:2];
          end
        end
        OFS_DATA: begin
          if (wb_we_i) begin
            ccWe = hostOk && (s.ramSel == RS_CHAR);
            ufWe = hostOk && (s.ramSel == RS_FONT);
            icWe = hostOk && (s.ramSel == RS_ICON);
          end else begin
            n.rdat = {24'h0, s.dataReg};
            n.dataReg = hostRd;
          end
          n.ac = s.ctrl[CTRL_INC] ? s.ac + 11'd1 : s.ac - 11'd1;
        end
        OFS_POWER: begin
          n.rdat = s.power;
          if (wb_we_i) begin
            n.power = merge(s.power, wb_dat_i, wb_sel_i) & PWR_MASK;
          end
        end
        OFS_STATUS: begin
          n.rdat = {23'h0, s.follower, s.drive, s.frame[BLINK_BIT],
                    s.grp, s.row};
        end
        default: begin
          n.rdat = 32'h0000_0000;
        end
      endcase
    end

    nLines = s.ctrl[CTRL_LINES_LSB+:3];
    if (nLines > 3'(LINES)) begin
      nLines = 3'd0;
    end

    startSel = s.ctrl[CTRL_START_LSB+:3];
    if (startSel >= 3'(LINES)) begin
      startSel = 3'd0;
    end
    lineGrp = (s.grp < 3'(LINES)) ? s.grp : 3'd0;
    lineSum = {1'b0, startSel} + {1'b0, lineGrp};
    dispLine = (lineSum >= 4'(LINES)) ? 3'(lineSum - 4'(LINES))
                                      : lineSum[2:0];

    ccIdx = {dispLine, s.chr};
    code = ccRam[ccIdx];

    isUser = s.ctrl[CTRL_FONT_BANK] ? (code[6:5] == 2'b00)
                                    : (code[7:4] == 4'h0);
    ufCol = 7'(code[3:0]) * 7'd6 + 7'(s.dot);
    ufIdx = 9'({code[7], code[4]}) * 9'(SEGS) + 9'(ufCol);

    if (s.ctrl[CTRL_GRAPHICS]) begin
      pattern = ufRam[9'(dispLine) * 9'(SEGS) + 9'(s.col)];
    end else if (isUser) begin
      pattern = ufRam[ufIdx];
    end else begin
      pattern = rom_byte(code, s.dot);
    end

    atCursor = (s.ramSel == RS_CHAR) && (s.ac == {4'h0, ccIdx})
               && !s.ctrl[CTRL_GRAPHICS];
    pix = pattern[s.row];
    if (atCursor && s.ctrl[CTRL_CURSOR] && (s.row == 3'd7)) begin
      pix = 1'b1;
    end
    if (atCursor && s.ctrl[CTRL_BLINK] && s.frame[BLINK_BIT]) begin
      pix = ~pix;
    end

    if (s.grp == GRP_ICON_A) begin
      pix = iconRam[s.col][0];
    end else if (s.grp == GRP_ICON_B) begin
      pix = iconRam[s.col][1];
    end

    if (s.grp == GRP_ICON_A) begin
      comIdx = s.ctrl[CTRL_COM_REV] ? 6'(ICON_COM_B) : 6'(ICON_COM_A);
    end else if (s.grp == GRP_ICON_B) begin
      comIdx = s.ctrl[CTRL_COM_REV] ? 6'(ICON_COM_A) : 6'(ICON_COM_B);
    end else begin
      comIdx = {s.grp, s.row};
      if (s.ctrl[CTRL_COM_REV]) begin
        comIdx = 6'(ICON_COM_A - 1) - comIdx;
      end
    end

    rowBits = {pix, s.shift[SEGS-1:1]};
    if (s.ctrl[CTRL_SEG_REV]) begin
      for (int i = 0; i < SEGS; i++) begin
        rowBits[i] = (i == 0) ? pix : s.shift[SEGS-i];
      end
    end

    blank = !s.ctrl[CTRL_DISP_ON] || s.ctrl[CTRL_STANDBY]
            || s.ctrl[CTRL_SLEEP];
    n.drive = !blank;
    n.follower = s.power[PWR_FOLLOWER] || !blank;

    if (!s.ctrl[CTRL_STANDBY]) begin
      n.shift = {pix, s.shift[SEGS-1:1]};
      if (s.col == 7'(SEGS - 1)) begin
        n.seg = rowBits;
        n.com = COMS'(1) << comIdx;
        n.col = 7'd0;
        n.chr = 4'h0;
        n.dot = 3'd0;
        if (s.grp < 3'(LINES)) begin
          if (s.row == 3'd7) begin
            n.row = 3'd0;
            n.grp = (s.grp + 3'd1 < nLines) ? s.grp + 3'd1 : GRP_ICON_A;
          end else begin
            n.row = s.row + 3'd1;
          end
        end else if (s.grp == GRP_ICON_A) begin
          n.grp = GRP_ICON_B;
        end else begin
          n.grp = (nLines != 3'd0) ? 3'd0 : GRP_ICON_A;
          n.frame = s.frame + 5'd1;
        end
      end else begin
        n.col = s.col + 7'd1;
        n.dot = (s.dot == 3'd5) ? 3'd0 : s.dot + 3'd1;
        n.chr = (s.dot == 3'd5) ? s.chr + 4'h1 : s.chr;
      end
    end
    if (blank) begin
      n.seg = '0;
      n.com = '0;
    end

    if (!clkEn) begin
      n = s;
      ccWe = 1'b0;
      ufWe = 1'b0;
      icWe = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // State and memory registers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ccWe) begin
      ccRam[hostIdx[6:0]] <= wb_dat_i[7:0];
    end
    if (ufWe) begin
      ufRam[hostIdx] <= wb_dat_i[7:0];
    end
    if (icWe) begin
      iconRam[hostIdx[6:0]] <= wb_dat_i[1:0];
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign segOut = s.seg;
  assign comSel = s.com;
  assign driveOn = s.drive;
  assign oscStop = s.ctrl[CTRL_STANDBY];
  assign boostFactor = s.power[PWR_BOOST_LSB+:2];
  assign biasRatio = s.power[PWR_BIAS_LSB+:3];
  assign followerOn = s.follower;
  assign contrastLevel = s.power[PWR_CONTRAST_LSB+:5];

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  chk_addr_set:
  assert property (take && clkEn && wb_we_i && 8'(wb_adr_i) == OFS_ADDR
    |=> s.ac == $past(wb_dat_i[10:0])
        && s.ramSel == $past(wb_dat_i[13:12]))
    else $error("address set did not load the counter");

  chk_ac_step:
  assert property (take && clkEn && 8'(wb_adr_i) == OFS_DATA
    |=> (s.ac == $past(s.ac) + 11'd1) || (s.ac == $past(s.ac) - 11'd1))
    else $error("address counter did not step by one");

  chk_dummy_read:
  assert property (take && clkEn && !wb_we_i && 8'(wb_adr_i) == OFS_DATA
    |=> s.ack && wb_dat_o == {24'h0, $past(s.dataReg)})
    else $error("read did not return the prefetched byte");

  chk_row_latch:
  assert property (s.seg != $past(s.seg) && $past(s.drive) && s.drive
    |-> $past(s.col) == 7'(SEGS - 1))
    else $error("segments latched before the row was complete");

  chk_com_single:
  assert property ($onehot0(comSel))
    else $error("more than one common selected");

  chk_blank_out:
  assert property (clkEn && (!s.ctrl[CTRL_DISP_ON] || s.ctrl[CTRL_SLEEP])
    |=> segOut == '0 && comSel == '0 && !driveOn)
    else $error("drivers not grounded while blanked");

  chk_osc_stop:
  assert property (s.ctrl[CTRL_STANDBY] && clkEn
    |=> s.col == $past(s.col) && s.row == $past(s.row))
    else $error("scan ran during standby");

  chk_line_range:
  assert property (s.grp < 3'(LINES) |-> dispLine < 3'(LINES))
    else $error("display line out of range");

  chk_follow_on:
  assert property (driveOn |-> followerOn)
    else $error("followers off while drive active");

  chk_ack_once:
  assert property (take && clkEn |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

endmodule

// [dv/lcdms_panel.sv]
// Panel model: keeps the last row shown on every common electrode
`timescale 1ns/1ps
module lcdms_panel
  import lcdms_pkg::*;
(
  // Clock and hit-count clear
  input wire logic ref_clk,
  input wire logic clr,
  // Driver outputs
  input wire logic [SEGS-1:0] segOut,
  input wire logic [COMS-1:0] comSel,
  input wire logic driveOn
);
  logic [SEGS-1:0] rowSeen [COMS];
  int hits [COMS];
  // A row counts only while exactly one common is driven
  always @(posedge ref_clk) begin
    for (int k = 0; k < COMS; k++) begin
      if (clr) begin
        hits[k] <= 0;
      end else if (driveOn === 1'b1 && comSel[k] === 1'b1) begin
        if ($onehot(comSel)) begin
          hits[k] <= hits[k] + 1;
          rowSeen[k] <= segOut;
        end
      end
    end
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the display-memory scan core
`timescale 1ns/1ps
module testbench;
  import lcdms_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [SEGS-1:0] segOut;
  logic [COMS-1:0] comSel;
  logic driveOn, oscStop, followerOn;
  logic [1:0] boostFactor;
  logic [2:0] biasRatio;
  logic [4:0] contrastLevel;
  logic panelClr = 1'b0;
  logic [31:0] rd;
  logic [SEGS-1:0] expRow, evenMask;
  logic [COMS-1:0] comHeld;
  int n_errors = 0;
  int n_checks = 0;

  lcdms_scan dut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .segOut(segOut), .comSel(comSel), .driveOn(driveOn),
    .oscStop(oscStop), .boostFactor(boostFactor), .biasRatio(biasRatio),
    .followerOn(followerOn), .contrastLevel(contrastLevel));

  lcdms_panel panel (.ref_clk(ref_clk), .clr(panelClr), .segOut(segOut),
    .comSel(comSel), .driveOn(driveOn));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [SEGS-1:0] seen, input logic [SEGS-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Request stands until ack is seen at a rising edge, then drops a cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat);
    int t;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wbAck !== 1'b1 && t < 20);
    if (wbAck !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: bus cycle got no ack", $time);
      complete_run();
    end else begin
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask

  task automatic rdr(input logic [7:0] adr);
    wb_cycle(1'b0, adr, 32'h0);
  endtask

  task automatic set_addr(input logic [1:0] sel, input logic [10:0] a);
    wr(OFS_ADDR, (32'(sel) << ADDR_SEL_LSB) | 32'(a));
  endtask

  // Two longest frames, so every active row is refreshed at least once
  task automatic scan(input logic [31:0] ctrl);
    wr(OFS_CTRL, ctrl);
    repeat (SEGS) @(posedge ref_clk);
    panelClr <= 1'b1;
    @(posedge ref_clk);
    panelClr <= 1'b0;
    repeat (2 * COMS * SEGS) @(posedge ref_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({wbAck, driveOn, oscStop, followerOn}, 0);
    chk(segOut, 0);
    chk(comSel, 0);
    rdr(OFS_CTRL);
    chk(rd, CTRL_RST);
    rdr(OFS_POWER);
    chk(rd, PWR_RST);
    rdr(8'h14);
    chk(rd, 0);
    // Character memory: stepping, dummy read, top boundary
    set_addr(RS_CHAR, 11'h000);
    for (int i = 0; i < 3; i++) wr(OFS_DATA, 32'hC0 + i);
    set_addr(RS_CHAR, 11'h04F);
    wr(OFS_DATA, 32'h5A);
    wr(OFS_DATA, 32'hA5);
    set_addr(RS_CHAR, 11'h000);
    rdr(OFS_DATA);
    for (int i = 0; i < 3; i++) begin
      rdr(OFS_DATA);
      chk(rd & 32'hFF, 32'hC0 + i);
    end
    wr(OFS_CTRL, 32'h0000_0010);
    set_addr(RS_CHAR, 11'h002);
    rdr(OFS_DATA);
    for (int i = 2; i >= 0; i--) begin
      rdr(OFS_DATA);
      chk(rd & 32'hFF, 32'hC0 + i);
    end
    set_addr(RS_CHAR, 11'h04F);
    rdr(OFS_DATA);
    rdr(OFS_DATA);
    chk(rd & 32'hFF, 32'h5A);
    rdr(OFS_ADDR);
    chk(rd, 32'h0000_004D);
    // Power settings
    wr(OFS_POWER, 32'h0015_0162);
    @(posedge ref_clk);
    chk({boostFactor, biasRatio, followerOn, contrastLevel},
        {2'h2, 3'h6, 1'b1, 5'h15});
    wbSel <= 4'h1;
    wr(OFS_POWER, 32'h0);
    wbSel <= 4'hF;
    rdr(OFS_POWER);
    chk(rd, 32'h0015_0100);
    wr(OFS_POWER, 32'hFFFF_FFFF);
    rdr(OFS_POWER);
    chk(rd, PWR_MASK);
    wr(OFS_POWER, 32'h0);
    @(posedge ref_clk);
    chk(followerOn, 0);
    // Graphics bitmap and icon memory
    wr(OFS_CTRL, 32'h0002_0018);
    set_addr(RS_FONT, 11'h000);
    for (int c = 0; c < SEGS; c++) wr(OFS_DATA, c);
    set_addr(RS_ICON, 11'h000);
    for (int c = 0; c < SEGS; c++) begin
      wr(OFS_DATA, c[0] ? 32'h0 : 32'h3);
      evenMask[c] = ~c[0];
    end
    scan(32'h0002_0019);
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < SEGS; c++) expRow[c] = c[r];
      chk(panel.rowSeen[r], expRow);
    end
    chk(panel.rowSeen[ICON_COM_A], evenMask);
    chk(panel.rowSeen[ICON_COM_B], evenMask);
    // Line count codes
    for (int n = 1; n <= LINES; n++) begin
      scan(32'h0002_0009 | (32'(n) << CTRL_LINES_LSB));
      chk(panel.hits[8 * n - 1] > 0, 1);
      if (n < LINES) chk(panel.hits[8 * n], 0);
    end
    scan(32'h0002_1019);
    for (int c = 0; c < SEGS; c++) expRow[SEGS - 1 - c] = c[0];
    chk(panel.rowSeen[0], expRow);
    // Character mode: start line 1, two lines, bank 1, cursor at 0x12
    set_addr(RS_CHAR, 11'h010);
    for (int i = 0; i < 32; i++) wr(OFS_DATA, (i < 16) ? 32'h01 : 32'h81);
    set_addr(RS_FONT, 11'h206);
    for (int i = 0; i < 6; i++) wr(OFS_DATA, 32'h3C);
    set_addr(RS_CHAR, 11'h012);
    scan(32'h0003_4121);
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < SEGS; c++) begin
        expRow[c] = (r == 7) ? (c / 6 == 2) : 1'((6 + c % 6) >> r);
      end
      chk(panel.rowSeen[r], expRow);
      expRow = {SEGS{r >= 2 && r <= 5}};
      chk(panel.rowSeen[8 + r], expRow);
    end
    // Clock enable low freezes the whole scan
    clkEn <= 1'b0;
    @(posedge ref_clk);
    expRow = segOut;
    comHeld = comSel;
    repeat (2 * SEGS) @(posedge ref_clk);
    chk(segOut, expRow);
    chk(comSel, comHeld);
    clkEn <= 1'b1;
    // Standby and blanking
    wr(OFS_CTRL, 32'h0002_001B);
    repeat (3) @(posedge ref_clk);
    chk({oscStop, driveOn}, 2'b10);
    chk(segOut, 0);
    chk(comSel, 0);
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rdr(OFS_CTRL);
    chk(rd, CTRL_MASK);
    wr(OFS_CTRL, 32'h0002_0018);
    repeat (3) @(posedge ref_clk);
    chk({driveOn, segOut === '0, comSel === '0}, 3'b011);
    complete_run();
  end
endmodule
